// ===== hw/dacfc_pkg.sv
// Package of constants for the dual converter clock and format control.
// Contract
// - Strap ground or third: offset binary.
// - Strap two thirds or full: two's complement.
// - Stabilizer on only at middle levels.
// - One strap governs both channels alike; here the stabilizer serves channel A only.
// - Stabilizer on: sample on rising edge.
// - Stabilizer on: falling edge from loop; here the pin's falling edge is used until the loop locks.
// - Accept 40-60% duty, keep 50% inside; here 50% holds only once the loop locks.
// - Loop relocks in about hundred cycles.
// - Overrange flag high beyond conversion range.
// - Each channel: own 12-bit bus plus flag.
package dacfc_pkg;

  // ***************************************************************
  // Widths and strap levels
  // ***************************************************************
  localparam int DATA_W = 12;
  localparam int STRAP_W = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int WORD_W = DATA_W + 1;

  typedef enum logic [1:0] {
    DACFC_STRAP_GND,
    DACFC_STRAP_THIRD,
    DACFC_STRAP_TWO_THIRDS,
    DACFC_STRAP_FULL
  } dacfc_strap_e;

  // ***************************************************************
  // Duty and lock figures
  // ***************************************************************
  localparam int DUTY_MIN_PCT = 40;
  localparam int DUTY_MAX_PCT = 60;
  localparam int RELOCK_CYCLES = 100;
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  // Sample clock period of this many system cycles or longer counts as stopped.
  localparam logic [CNT_W-1:0] STOP_CYCLES = 16'h0100;
  localparam logic [6:0] RELOCK_CNT = 7'h64;
  localparam logic [DATA_W-1:0] MSB_FLIP = 12'h800;

endpackage

// ===== hw/dacfc_fifo.sv
// Parameterised valid/ready FIFO for result words.
`timescale 1ns/1ps
module dacfc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 16
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset, active low
  input wire logic in_valid, // write request
  output logic in_ready, // space available
  input wire logic [WIDTH-1:0] in_data, // write word
  output logic out_valid, // word available
  input wire logic out_ready, // reader takes word
  output logic [WIDTH-1:0] out_data // head word
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ===== hw/dacfc_top.sv
// Strap decode and output formatting for both channels, clock stabilizer tracking for channel A.
`timescale 1ns/1ps
module dacfc_top (
  input wire logic clk, // system clock, 100 MHz
  input wire logic rstn, // asynchronous reset, active low
  input wire logic [1:0] mode_strap, // four-level mode strap, quantised
  input wire logic channel_a_sample_clock, // channel A sample clock pin
  input wire logic channel_b_sample_clock, // channel B sample clock pin
  input wire logic [11:0] code_a, // channel A raw offset-binary code
  input wire logic [11:0] code_b, // channel B raw offset-binary code
  input wire logic over_a, // channel A input beyond range
  input wire logic over_b, // channel B input beyond range
  output logic [11:0] bus_a, // channel A result, bus_a[11] is bus_a_top_bit
  output logic overrange_flag_a, // channel A overrange flag
  output logic [11:0] bus_b, // channel B result
  output logic overrange_flag_b, // channel B overrange flag
  output logic result_valid, // result pair presented
  input wire logic result_ready, // downstream takes the pair
  output logic twos_complement, // format in force for both channels
  output logic stabilizer_on, // stabilizer state, applied to channel A only
  output logic loop_locked, // stabilizer loop locked
  output logic internal_clock // internal clock, channel A; 50% only when the stabilizer is on and the loop locked
);
  localparam int DW = dacfc_pkg::DATA_W;
  localparam int WW = 2 * dacfc_pkg::WORD_W;

  // ***************************************************************
  // Reset release
  // ***************************************************************
  // The reset pin is asserted at once but released through two flops.
  // Every register below uses the released copy, so no register sees
  // a release edge that lands too close to the clock edge.
  // The pin itself never reaches any logic except these two flops.
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  // The strap and both sample clocks are not tied to the system clock.
  // Each passes two flops before any logic reads it.
  // A third flop on the clocks keeps the previous level for edge detection.
  // The previous level resets low, which is the idle level of a stopped
  // clock, so no false rising edge follows reset.
  logic [1:0] strap_meta;
  logic [1:0] strap_sync;
  logic [1:0] clk_meta;
  logic [1:0] clk_sync;
  logic [1:0] clk_prev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= 2'h0;
      strap_sync <= 2'h0;
      clk_meta <= 2'h0;
      clk_sync <= 2'h0;
      clk_prev <= 2'h0;
    end else begin
      strap_meta <= mode_strap;
      strap_sync <= strap_meta;
      clk_meta <= {channel_b_sample_clock, channel_a_sample_clock};
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
    end
  end

  // ***************************************************************
  // Strap decode shared by both channels
  // ***************************************************************
  dacfc_pkg::dacfc_strap_e strap;
  logic next_twos;
  logic next_stab;

  always_comb begin
    strap = dacfc_pkg::dacfc_strap_e'(strap_sync);
    case (strap)
      dacfc_pkg::DACFC_STRAP_GND: begin
        next_twos = 1'b0;
        next_stab = 1'b0;
      end
      dacfc_pkg::DACFC_STRAP_THIRD: begin
        next_twos = 1'b0;
        next_stab = 1'b1;
      end
      dacfc_pkg::DACFC_STRAP_TWO_THIRDS: begin
        next_twos = 1'b1;
        next_stab = 1'b1;
      end
      dacfc_pkg::DACFC_STRAP_FULL: begin
        next_twos = 1'b1;
        next_stab = 1'b0;
      end
      default: begin
        next_twos = 1'b0;
        next_stab = 1'b0;
      end
    endcase
  end

  // One flop pair holds the settings; the format flop drives both channels so both are formatted alike at any one edge.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      twos_complement <= 1'b0;
      stabilizer_on <= 1'b0;
    end else begin
      twos_complement <= next_twos;
      stabilizer_on <= next_stab;
    end
  end

  // ***************************************************************
  // Per-channel edge detection and formatting
  // ***************************************************************
  // Both channels run through the same logic here, one copy per channel.
  // The single format flop feeds every copy, so both channels are formatted
  // alike at any one edge; a pair spanning a format change can mix formats.
  // Two's complement is the offset-binary code with its top bit inverted.
  // Midscale therefore maps to zero.
  logic rise_a;
  logic rise_b;
  logic [1:0] rise;
  logic [DW-1:0] raw_code [2];
  logic [DW-1:0] fmt_code [2];
  logic [DW-1:0] fmt_a;
  logic [DW-1:0] fmt_b;

  assign raw_code[0] = code_a;
  assign raw_code[1] = code_b;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    assign rise[ch] = clk_sync[ch] && !clk_prev[ch];
    assign fmt_code[ch] = twos_complement ?
      (raw_code[ch] ^ dacfc_pkg::MSB_FLIP) : raw_code[ch];
  end

  assign rise_a = rise[0];
  assign rise_b = rise[1];
  assign fmt_a = fmt_code[0];
  assign fmt_b = fmt_code[1];

  // ***************************************************************
  // Channel A stabilizer: period measurement and lock
  // ***************************************************************
  logic fall_a;
  logic [dacfc_pkg::CNT_W-1:0] period_cnt;
  logic [dacfc_pkg::CNT_W-1:0] period;
  logic [dacfc_pkg::CNT_W-1:0] phase_cnt;
  logic [6:0] lock_cnt;
  logic stopped;

  // The period counter saturates rather than wraps.
  // A wrap would make a stopped clock look like a running one and would
  // let the loop keep a lock that it no longer has.
  // A clock counts as stopped once no rising edge has come for a long time.
  assign fall_a = !clk_sync[0] && clk_prev[0];
  assign stopped = (period_cnt >= dacfc_pkg::STOP_CYCLES);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      period_cnt <= dacfc_pkg::CNT_ZERO;
      period <= dacfc_pkg::CNT_ZERO;
    end else if (rise_a) begin
      period_cnt <= dacfc_pkg::CNT_ONE;
      period <= period_cnt;
    end else if (period_cnt != dacfc_pkg::CNT_MAX) begin
      period_cnt <= period_cnt + dacfc_pkg::CNT_ONE;
    end
  end

  // A stopped clock drops lock; rising edges are counted up to relock.
  // Turning the stabilizer off clears the count as well.
  // Lock therefore always needs the full count of edges after a restart.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_cnt <= 7'h00;
      loop_locked <= 1'b0;
    end else if (!stabilizer_on || stopped) begin
      lock_cnt <= 7'h00;
      loop_locked <= 1'b0;
    end else if (rise_a && !loop_locked) begin
      if (lock_cnt == dacfc_pkg::RELOCK_CNT - 7'h01) begin
        loop_locked <= 1'b1;
      end
      lock_cnt <= lock_cnt + 7'h01;
    end
  end

  // ***************************************************************
  // Internal clock: rising edge follows pin, falling edge regenerated once the loop locks
  // ***************************************************************
  // Until the loop is locked the pin's own falling edge is used.
  // This keeps the internal clock usable while the loop relocks.
  // The regenerated fall uses the last measured period, rounded down.
  // The internal clock follows channel A only.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_cnt <= dacfc_pkg::CNT_ZERO;
      internal_clock <= 1'b0;
    end else if (rise_a) begin
      phase_cnt <= dacfc_pkg::CNT_ONE;
      internal_clock <= 1'b1;
    end else begin
      phase_cnt <= phase_cnt + dacfc_pkg::CNT_ONE;
      if (stabilizer_on && loop_locked) begin
        // Pin falling edge ignored; fall at half the measured period.
        if (phase_cnt >= (period >> 1)) begin
          internal_clock <= 1'b0;
        end
      end else if (fall_a) begin
        internal_clock <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Sample capture and formatting
  // ***************************************************************
  logic take_a;
  logic take_b;
  logic have_a;
  logic [DW-1:0] hold_a;
  logic hold_ov_a;
  logic fifo_in_ready;
  logic fifo_valid;
  logic [WW-1:0] fifo_word;
  logic [WW-1:0] in_word;

  // Both channels sample on the rising edge of their own clock.
  assign take_a = rise_a;
  assign take_b = rise_b;
  // Channel A is held until channel B's next edge completes the pair.
  // A newer channel A sample overwrites an older one that was never paired.
  // The format in force at capture time is the one stored with the sample.
  // A channel B edge with no held channel A sample is ignored.
  assign in_word = {over_b, fmt_b, hold_ov_a, hold_a};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      have_a <= 1'b0;
      hold_a <= 12'h000;
      hold_ov_a <= 1'b0;
    end else begin
      if (take_a) begin
        hold_a <= fmt_a;
        hold_ov_a <= over_a;
        have_a <= 1'b1;
      end else if (take_b && fifo_in_ready) begin
        have_a <= 1'b0;
      end
    end
  end

  // Pair is queued at channel B's edge; a full FIFO drops channel B's sample and channel A stays held.
  dacfc_fifo #(
    .WIDTH(WW),
    .DEPTH(dacfc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(take_b && have_a),
    .in_ready(fifo_in_ready),
    .in_data(in_word),
    .out_valid(fifo_valid),
    .out_ready(!result_valid || result_ready),
    .out_data(fifo_word)
  );

  // ***************************************************************
  // Output register
  // ***************************************************************
  // The pair stands on the outputs until downstream takes it.
  // A new pair is loaded only when the output is empty or being taken.
  // All outputs come straight from flops.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_valid <= 1'b0;
      bus_a <= 12'h000;
      bus_b <= 12'h000;
      overrange_flag_a <= 1'b0;
      overrange_flag_b <= 1'b0;
    end else if (!result_valid || result_ready) begin
      result_valid <= fifo_valid;
      if (fifo_valid) begin
        bus_a <= fifo_word[DW-1:0];
        overrange_flag_a <= fifo_word[DW];
        bus_b <= fifo_word[WW-2:DW+1];
        overrange_flag_b <= fifo_word[WW-1];
      end
    end
  end
endmodule

// ===== test/dacfc_props.sv
// Concurrent checks on the ports of the converter control block.
`timescale 1ns/1ps
module dacfc_props (
  input wire logic clk, // system clock
  input wire logic rstn, // reset, active low
  input wire logic [1:0] mode_strap, // strap level
  input wire logic result_valid, // pair presented
  input wire logic result_ready, // pair taken
  input wire logic [11:0] bus_a, // channel A result
  input wire logic [11:0] bus_b, // channel B result
  input wire logic overrange_flag_a, // channel A flag
  input wire logic overrange_flag_b, // channel B flag
  input wire logic twos_complement, // format in force
  input wire logic stabilizer_on, // stabilizer state
  input wire logic loop_locked // loop lock
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic [15:0] on_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      on_cnt <= 16'h0000;
    end else if (!stabilizer_on) begin
      on_cnt <= 16'h0000;
    end else if (on_cnt != 16'hffff) begin
      on_cnt <= on_cnt + 16'h0001;
    end
  end
  sequence s_strap(logic [1:0] v);
    (mode_strap == v) [*8];
  endsequence
  sequence s_wait;
    result_valid && !result_ready;
  endsequence
  a_format_straight: assert property ((s_strap(2'h0) or s_strap(2'h1)) |-> !twos_complement)
    else $error("format not offset binary");
  a_format_twos: assert property ((s_strap(2'h2) or s_strap(2'h3)) |-> twos_complement)
    else $error("format not twos complement");
  a_stab_middle: assert property ((s_strap(2'h1) or s_strap(2'h2)) |-> stabilizer_on)
    else $error("stabilizer off at middle level");
  a_stab_ends: assert property ((s_strap(2'h0) or s_strap(2'h3)) |-> !stabilizer_on)
    else $error("stabilizer on at end level");
  a_result_hold: assert property (s_wait |=> result_valid && $stable(bus_a) && $stable(bus_b))
    else $error("result changed while waiting");
  a_flag_hold: assert property (s_wait |=> $stable({overrange_flag_a, overrange_flag_b}))
    else $error("flag changed while waiting");
  a_lock_count: assert property ($rose(loop_locked) |-> on_cnt >= 16'h00c6)
    else $error("lock came too early");
  a_lock_off: assert property (!stabilizer_on [*3] |-> !loop_locked)
    else $error("lock without stabilizer");
endmodule

// ===== test/dacfc_sink.sv
// Downstream capture logic taking result pairs, able to stall.
`timescale 1ns/1ps
module dacfc_sink (
  input wire logic clk, // system clock
  input wire logic stall, // hold off taking pairs
  input wire logic result_valid, // pair presented
  input wire logic [11:0] bus_a, // channel A result
  input wire logic [11:0] bus_b, // channel B result
  input wire logic overrange_flag_a, // channel A flag
  input wire logic overrange_flag_b, // channel B flag
  output logic result_ready, // pair taken at this edge
  output logic [25:0] got, // last pair taken
  output int count // pairs taken
);
  initial begin
    result_ready = 1'b0;
    got = 26'h000_0000;
    count = 0;
  end
  always @(posedge clk) begin
    result_ready <= !stall;
    if (result_valid === 1'b1 && result_ready) begin
      got <= {bus_a, overrange_flag_a, bus_b, overrange_flag_b};
      count <= count + 1;
    end
  end
endmodule

// ===== test/testbench.sv
// Self-checking bench for the converter clock and format control.
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [1:0] strap; logic [11:0] ca; logic [11:0] cb; logic oa; logic ob;
    logic tc; logic st; logic [11:0] ea; logic [11:0] eb;
  } dacfc_row_s;
  localparam dacfc_row_s ROWS [4] = '{
    '{2'h0, 12'h0800, 12'h07ff, 1'b0, 1'b0, 1'b0, 1'b0, 12'h0800, 12'h07ff},
    '{2'h1, 12'h0000, 12'h0fff, 1'b1, 1'b0, 1'b0, 1'b1, 12'h0000, 12'h0fff},
    '{2'h2, 12'h0800, 12'h07ff, 1'b0, 1'b1, 1'b1, 1'b1, 12'h0000, 12'h0fff},
    '{2'h3, 12'h0fff, 12'h0001, 1'b1, 1'b1, 1'b1, 1'b0, 12'h07ff, 12'h0801}};
  logic clk, rstn, sclk, run, stall, over_a, over_b, result_valid, result_ready;
  logic [1:0] mode_strap;
  logic [11:0] code_a, code_b, bus_a, bus_b;
  logic overrange_flag_a, overrange_flag_b, twos_complement, stabilizer_on;
  logic loop_locked, internal_clock;
  logic [25:0] got;
  int count, hi, phase, mismatches, total_checks, c, hc;
  dacfc_top dut (.clk(clk), .rstn(rstn), .mode_strap(mode_strap),
    .channel_a_sample_clock(sclk), .channel_b_sample_clock(sclk),
    .code_a(code_a), .code_b(code_b), .over_a(over_a), .over_b(over_b), .bus_a(bus_a),
    .overrange_flag_a(overrange_flag_a), .bus_b(bus_b), .overrange_flag_b(overrange_flag_b),
    .result_valid(result_valid), .result_ready(result_ready),
    .twos_complement(twos_complement), .stabilizer_on(stabilizer_on),
    .loop_locked(loop_locked), .internal_clock(internal_clock));
  dacfc_sink sink (.clk(clk), .stall(stall), .result_valid(result_valid), .bus_a(bus_a),
    .bus_b(bus_b), .overrange_flag_a(overrange_flag_a), .overrange_flag_b(overrange_flag_b),
    .result_ready(result_ready), .got(got), .count(count));
  task automatic check(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_count(input int n);
    int target;
    target = count + n;
    for (int i = 0; i < 2000 && count < target; i++) cycles(1);
    check(count >= target, 1);
  endtask
  task automatic wrap_up;
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Shared sample clock of ten system cycles, 10 Msps, high for hi cycles.
  initial begin
    sclk = 1'b0;
    phase = 0;
    forever begin
      @(posedge clk);
      #1;
      phase = (run && phase < 9) ? phase + 1 : 0;
      sclk = run && phase < hi;
    end
  end
  initial begin
    #200000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {rstn, run, stall, over_a, over_b, mode_strap, code_a, code_b} = '0;
    hi = 5;
    cycles(5);
    check({result_valid, twos_complement, stabilizer_on, loop_locked, bus_a}, 0);
    rstn = 1'b1;
    run = 1'b1;
    foreach (ROWS[i]) begin
      {mode_strap, code_a, code_b, over_a, over_b} = ROWS[i][53:26];
      cycles(40);
      check({twos_complement, stabilizer_on}, {ROWS[i].tc, ROWS[i].st});
      wait_count(2);
      check(got, {ROWS[i].ea, ROWS[i].oa, ROWS[i].eb, ROWS[i].ob});
    end
    mode_strap = 2'h1;
    run = 1'b0;
    cycles(300);
    check(loop_locked, 0);
    run = 1'b1;
    cycles(900);
    check(loop_locked, 0);
    cycles(200);
    check(loop_locked, 1);
    for (int k = 0; k < 3; k++) begin
      if (k == 2) mode_strap = 2'h0;
      hi = (k == 1) ? 6 : 4;
      cycles(40);
      hc = 0;
      repeat (20) begin
        cycles(1);
        hc += internal_clock;
      end
      check(hc, (k == 2) ? 8 : 10);
    end
    stall = 1'b1;
    cycles(300);
    run = 1'b0;
    cycles(20);
    check(result_valid, 1);
    c = count;
    stall = 1'b0;
    cycles(100);
    check(count - c, 17);
    wrap_up();
  end
endmodule
bind dacfc_top dacfc_props u_props (.clk(clk), .rstn(rstn), .mode_strap(mode_strap),
  .result_valid(result_valid), .result_ready(result_ready), .bus_a(bus_a), .bus_b(bus_b),
  .overrange_flag_a(overrange_flag_a), .overrange_flag_b(overrange_flag_b),
  .twos_complement(twos_complement), .stabilizer_on(stabilizer_on),
  .loop_locked(loop_locked));
